// ### verilog/css_pkg.sv
// Constants for the configuration source selector of the hub.
// Assumes a single 250 MHz system clock and a plain register port.
package css_pkg;

    // ------------------------------------------------------------
    // Clock and reset timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int RESET_MIN_NS = 1000;
    // Least reset width, rounded up to whole cycles
    localparam int RESET_MIN_CYC =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 9;

    // ------------------------------------------------------------
    // Slave addresses for descriptor download
    // ------------------------------------------------------------
    localparam logic [6:0] SMB_ADDR_LO = 7'h2C; // 0101100
    localparam logic [6:0] SMB_ADDR_HI = 7'h2D; // 0101101
    localparam logic [6:0] SMB_ADDR_NONE = 7'h00;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;

    // Control register fields
    localparam int CTRL_DONE_BIT = 0;
    localparam int CTRL_SELF_BIT = 1;
    localparam logic CTRL_SELF_RST = 1'b0;

    // Status register fields
    localparam int ST_SEL_LSB = 0;
    localparam int ST_EXTCLK_BIT = 3;
    localparam int ST_SELF_BIT = 4;
    localparam int ST_SHORT_BIT = 5;
    localparam int ST_READY_BIT = 6;
    localparam int ST_METH_LSB = 8;

    // Configuration methods
    typedef enum logic [2:0] {
        METH_SMB_LO = 3'b000,
        METH_SMB_HI = 3'b001,
        METH_INTERNAL = 3'b010,
        METH_STRAPPED = 3'b011,
        METH_EEPROM = 3'b100
    } css_method_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_STRAP = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } css_state_t;

endpackage

// ### verilog/css_sync2.sv
// Two-stage synchroniser for a group of board pins.
// Assumes the pins are quasi-static; bits are synchronised separately.
`timescale 1ns/1ns
module css_sync2 #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);

    // ------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------
    logic [W-1:0] meta_r;

    // First stage read only by the second stage; no reset so the
    // pins stay tracked while the chip reset is held
    always_ff @(posedge sys_clk) begin
        meta_r <= asyncIn;
        syncOut <= meta_r;
    end

endmodule

// ### verilog/css_config_select.sv
// Configuration source selector: catches the method-select straps at
// reset release and steers the hub to its configuration source.
// Assumes rstn is the chip reset, pins are asynchronous to sys_clk.
//
// How it works
// - Select pattern x00 makes the hub an SMBus slave at 0101100.
// - Select pattern x01 makes the hub an SMBus slave at 0101101.
// - Pattern 010 uses internal defaults, 110 defaults with straps.
// - Pattern x11 loads the configuration from a serial EEPROM as master.
// - Clock select low runs the crystal, high takes an external clock.
// - Supply detect high means local power, low means bus power only.
// - The select pins are sampled as reset is released.
// - With internal defaults, power status follows the supply detect pin.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module css_config_select #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input wire logic sys_clk,
    input wire logic rstn,
    // Board straps and detect pins
    input wire logic method_select_hi,
    input wire logic method_select_mid,
    input wire logic method_select_lo,
    input wire logic ext_clock_select,
    input wire logic local_supply_detect,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    // Configuration source selection
    output logic smbSlaveEn,
    output logic [6:0] smbSlaveAddr,
    output logic eepromMasterEn,
    output logic internalCfgEn,
    output logic strapOverrideEn,
    output logic oscDriveEn,
    output logic extClockEn,
    output logic selfPowered,
    output logic configReady
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [4:0] pinsAsync;
    logic [4:0] pinsSync;
    logic [2:0] selSync;
    logic extClkSync;
    logic supplySync;

    assign pinsAsync = {local_supply_detect, ext_clock_select,
                        method_select_hi, method_select_mid,
                        method_select_lo};

    css_sync2 #(
        .W(5)
    ) u_sync (
        .sys_clk(sys_clk),
        .asyncIn(pinsAsync),
        .syncOut(pinsSync)
    );

    assign selSync = pinsSync[2:0];
    assign extClkSync = pinsSync[3];
    assign supplySync = pinsSync[4];

    // ------------------------------------------------------------
    // Method decoding
    // ------------------------------------------------------------
    // Map the three select bits to a configuration method
    function automatic css_pkg::css_method_t decodeMethod(
        input logic [2:0] sel
    );
        css_pkg::css_method_t m;
        if (sel[1:0] == 2'b00) begin
            m = css_pkg::METH_SMB_LO;
        end else if (sel[1:0] == 2'b01) begin
            m = css_pkg::METH_SMB_HI;
        end else if (sel == 3'b010) begin
            m = css_pkg::METH_INTERNAL;
        end else if (sel == 3'b110) begin
            m = css_pkg::METH_STRAPPED;
        end else begin
            m = css_pkg::METH_EEPROM;
        end
        return m;
    endfunction

    // Slave address belonging to a method
    function automatic logic [6:0] methodAddr(
        input css_pkg::css_method_t m
    );
        logic [6:0] a;
        a = css_pkg::SMB_ADDR_NONE;
        if (m == css_pkg::METH_SMB_LO) begin
            a = css_pkg::SMB_ADDR_LO;
        end else if (m == css_pkg::METH_SMB_HI) begin
            a = css_pkg::SMB_ADDR_HI;
        end
        return a;
    endfunction

    // ------------------------------------------------------------
    // State and latched straps
    // ------------------------------------------------------------
    css_pkg::css_state_t state_r;
    css_pkg::css_state_t state_nxt;
    css_pkg::css_method_t method_r;
    css_pkg::css_method_t sampledMethod;
    logic [2:0] selLatch_r;
    logic extClk_r;
    logic shortReset_r;
    logic selfCfg_r;
    logic [css_pkg::RST_CNT_W-1:0] lowCnt_r;
    logic [css_pkg::RST_CNT_W-1:0] lowCnt_nxt;
    logic lowCntSat;
    logic sampleNow;
    logic isInternal;
    logic isSmb;
    logic selfPowered_nxt;

    assign sampledMethod = decodeMethod(selSync);
    assign sampleNow = (state_r == css_pkg::ST_STRAP);
    assign isInternal = (method_r == css_pkg::METH_INTERNAL) ||
                        (method_r == css_pkg::METH_STRAPPED);
    assign isSmb = (method_r == css_pkg::METH_SMB_LO) ||
                   (method_r == css_pkg::METH_SMB_HI);

    // ------------------------------------------------------------
    // Register port decoding
    // ------------------------------------------------------------
    logic selCtrl;
    logic selStatus;
    logic selAddr;
    logic ctrlWr;
    logic doneWr;
    logic [DATA_W-1:0] statusWord;
    logic [DATA_W-1:0] ctrlWord;
    logic [DATA_W-1:0] addrWord;
    logic [DATA_W-1:0] readMux;

    assign selCtrl = (regAddr == ADDR_W'(css_pkg::REG_CTRL));
    assign selStatus = (regAddr == ADDR_W'(css_pkg::REG_STATUS));
    assign selAddr = (regAddr == ADDR_W'(css_pkg::REG_ADDR));
    assign ctrlWr = regWr && selCtrl;
    assign doneWr = ctrlWr && regWdata[css_pkg::CTRL_DONE_BIT];

    // Status word: latched straps, clock choice, power, progress
    always_comb begin
        statusWord = '0;
        statusWord[css_pkg::ST_SEL_LSB +: 3] = selLatch_r;
        statusWord[css_pkg::ST_EXTCLK_BIT] = extClk_r;
        statusWord[css_pkg::ST_SELF_BIT] = selfPowered;
        statusWord[css_pkg::ST_SHORT_BIT] = shortReset_r;
        statusWord[css_pkg::ST_READY_BIT] = configReady;
        statusWord[css_pkg::ST_METH_LSB +: 3] = method_r;
    end

    // Control word read back
    always_comb begin
        ctrlWord = '0;
        ctrlWord[css_pkg::CTRL_DONE_BIT] = configReady;
        ctrlWord[css_pkg::CTRL_SELF_BIT] = selfCfg_r;
    end

    assign addrWord = {{(DATA_W-7){1'b0}}, smbSlaveAddr};
    // Unmapped addresses read as zero
    always_comb begin
        if (selCtrl) begin
            readMux = ctrlWord;
        end else if (selStatus) begin
            readMux = statusWord;
        end else if (selAddr) begin
            readMux = addrWord;
        end else begin
            readMux = '0;
        end
    end

    // ------------------------------------------------------------
    // Reset width monitor
    // ------------------------------------------------------------
    // Counts cycles with reset low, saturating at the least width
    assign lowCntSat =
        (lowCnt_r >= css_pkg::RST_CNT_W'(css_pkg::RESET_MIN_CYC));
    assign lowCnt_nxt = lowCntSat ? lowCnt_r :
                        lowCnt_r + css_pkg::RST_CNT_W'(1);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            lowCnt_r <= lowCnt_nxt;
        end else if (sampleNow) begin
            lowCnt_r <= '0;
        end
    end

    // Flags a reset pulse shorter than the least width
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            shortReset_r <= 1'b0;
        end else if (sampleNow) begin
            shortReset_r <= !lowCntSat;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Strap capture, then wait for download or run on defaults
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            css_pkg::ST_STRAP: begin
                if (sampledMethod == css_pkg::METH_INTERNAL ||
                    sampledMethod == css_pkg::METH_STRAPPED) begin
                    state_nxt = css_pkg::ST_RUN;
                end else begin
                    state_nxt = css_pkg::ST_LOAD;
                end
            end
            css_pkg::ST_LOAD: begin
                if (doneWr) begin
                    state_nxt = css_pkg::ST_RUN;
                end
            end
            css_pkg::ST_RUN: begin
                state_nxt = css_pkg::ST_RUN;
            end
            default: begin
                state_nxt = css_pkg::ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_r <= css_pkg::ST_STRAP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Strap capture at reset release
    // ------------------------------------------------------------
    // Taken once in the first cycle after release, then held
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            method_r <= css_pkg::METH_INTERNAL;
            selLatch_r <= 3'h0;
            extClk_r <= 1'b0;
        end else if (sampleNow) begin
            method_r <= sampledMethod;
            selLatch_r <= selSync;
            extClk_r <= extClkSync;
        end
    end

    // Software power setting used when downloaded
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            selfCfg_r <= css_pkg::CTRL_SELF_RST;
        end else if (ctrlWr) begin
            selfCfg_r <= regWdata[css_pkg::CTRL_SELF_BIT];
        end
    end

    // ------------------------------------------------------------
    // Power status
    // ------------------------------------------------------------
    // Defaults follow the detect pin; downloads follow software
    assign selfPowered_nxt = isInternal ? supplySync : selfCfg_r;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            selfPowered <= 1'b0;
        end else if (!sampleNow) begin
            selfPowered <= selfPowered_nxt;
        end
    end

    // ------------------------------------------------------------
    // Source selection outputs
    // ------------------------------------------------------------
    // Outputs mirror the latched method once capture is done; slave and EEPROM enables only in ST_LOAD
    always_ff @(posedge sys_clk) begin
        if (!rstn || sampleNow) begin
            smbSlaveEn <= 1'b0;
            smbSlaveAddr <= css_pkg::SMB_ADDR_NONE;
            eepromMasterEn <= 1'b0;
            internalCfgEn <= 1'b0;
            strapOverrideEn <= 1'b0;
        end else begin
            smbSlaveEn <= isSmb && (state_r == css_pkg::ST_LOAD);
            smbSlaveAddr <= methodAddr(method_r);
            eepromMasterEn <= (method_r == css_pkg::METH_EEPROM) &&
                              (state_r == css_pkg::ST_LOAD);
            internalCfgEn <= isInternal;
            strapOverrideEn <= (method_r == css_pkg::METH_STRAPPED);
        end
    end

    // Clock source: crystal driver on unless external clock chosen
    always_ff @(posedge sys_clk) begin
        if (!rstn || sampleNow) begin
            oscDriveEn <= 1'b1;
            extClockEn <= 1'b0;
        end else begin
            oscDriveEn <= !extClk_r;
            extClockEn <= extClk_r;
        end
    end

    // Ready once defaults apply or software ends the download
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            configReady <= 1'b0;
        end else begin
            configReady <= (state_r == css_pkg::ST_RUN);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            regRdata <= '0;
        end else begin
            regRdata <= regRd ? readMux : '0;
        end
    end

endmodule

// ### test/css_config_select_sva.sv
// Checker for the configuration source selector outputs.
// Assumes binding to css_config_select; one clock, sync active-low reset.
`timescale 1ns/1ns
module css_config_select_sva (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic local_supply_detect,
    input wire logic smbSlaveEn,
    input wire logic [6:0] smbSlaveAddr,
    input wire logic eepromMasterEn,
    input wire logic internalCfgEn,
    input wire logic strapOverrideEn,
    input wire logic oscDriveEn,
    input wire logic extClockEn,
    input wire logic selfPowered,
    input wire logic configReady
);
    // ------------------------------------------------------------
    // Source selection properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    smb_addr_a: assert property (
        smbSlaveEn |-> smbSlaveAddr inside {7'h2C, 7'h2D})
        else $error("slave address wrong while slave active");
    clk_excl_a: assert property (
        oscDriveEn != extClockEn)
        else $error("crystal and external clock both or neither");
    src_excl_a: assert property (
        !(smbSlaveEn && eepromMasterEn) &&
        !(internalCfgEn && (smbSlaveEn || eepromMasterEn)))
        else $error("two configuration sources at once");
    strap_sub_a: assert property (
        strapOverrideEn |-> internalCfgEn)
        else $error("strap override without internal defaults");
    load_busy_a: assert property (
        (smbSlaveEn || eepromMasterEn) |-> !configReady)
        else $error("ready while download still active");
    int_ready_a: assert property (
        internalCfgEn |-> configReady)
        else $error("internal defaults but not ready");
    choice_hold_a: assert property (
        configReady |=> $stable(extClockEn) && $stable(internalCfgEn)
            && $stable(strapOverrideEn) && configReady)
        else $error("choice changed after configuration");
    supply_track_a: assert property (
        internalCfgEn && $past(internalCfgEn, 4) &&
        $stable(local_supply_detect) &&
        local_supply_detect == $past(local_supply_detect, 2) &&
        local_supply_detect == $past(local_supply_detect, 3) &&
        local_supply_detect == $past(local_supply_detect, 4)
        |-> selfPowered == local_supply_detect)
        else $error("power status does not follow supply detect");
endmodule

// ### test/css_strap_board.sv
// Board model: method straps, clock strap, supply detect, reset driver.
// Assumes the caller runs its tasks from the bench's main sequence.
`timescale 1ns/1ns
module css_strap_board (
    input wire logic sys_clk,
    output logic rstn,
    output logic [2:0] sel,
    output logic extSel,
    output logic supply
);
    // ------------------------------------------------------------
    // Strap and reset driving
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        sel = 3'h0;
        extSel = 1'b0;
        supply = 1'b0;
    end

    // Set straps, hold reset low n edges, then release
    task automatic strap(input logic [2:0] s, input logic e,
                         input logic p, input int n);
        @(posedge sys_clk);
        rstn <= 1'b0;
        sel <= s;
        extSel <= e;
        supply <= p;
        repeat (n) @(posedge sys_clk);
        rstn <= 1'b1;
    endtask

    // Move pins after capture
    task automatic pins(input logic [2:0] s, input logic e, input logic p);
        @(posedge sys_clk);
        sel <= s;
        extSel <= e;
        supply <= p;
    endtask
endmodule

// ### test/css_config_select_tb.sv
// Self-checking bench for the configuration source selector.
// Assumes the board model drives straps and reset; bench drives registers.
`timescale 1ns/1ns
module css_config_select_tb;
    // ------------------------------------------------------------
    // Clock, board, design
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rstn, extSel, supply, regWr, regRd, eOk;
    logic [2:0] sel;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, rs, d;
    logic smbSlaveEn, eepromMasterEn, internalCfgEn, strapOverrideEn;
    logic oscDriveEn, extClockEn, selfPowered, configReady;
    logic [6:0] smbSlaveAddr;
    int badCount = 0;
    int numChecks = 0;
    int m, intl;

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    css_strap_board brd (.sys_clk(sys_clk), .rstn(rstn), .sel(sel),
        .extSel(extSel), .supply(supply));

    css_config_select dut (.sys_clk(sys_clk), .rstn(rstn),
        .method_select_hi(sel[2]), .method_select_mid(sel[1]),
        .method_select_lo(sel[0]), .ext_clock_select(extSel),
        .local_supply_detect(supply), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .smbSlaveEn(smbSlaveEn),
        .smbSlaveAddr(smbSlaveAddr), .eepromMasterEn(eepromMasterEn),
        .internalCfgEn(internalCfgEn), .strapOverrideEn(strapOverrideEn),
        .oscDriveEn(oscDriveEn), .extClockEn(extClockEn),
        .selfPowered(selfPowered), .configReady(configReady));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Expected method code from the select pattern
    function automatic int meth(input logic [2:0] s);
        if (s[1:0] == 2'b11) return 4;
        if (s[1]) return s[2] ? 3 : 2;
        return s[0] ? 1 : 0;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    task automatic tallyAndFinish;
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence: every pattern with both clock straps
    // ------------------------------------------------------------
    initial begin
        regWr <= 1'b0;
        regRd <= 1'b0;
        regAddr <= 8'h00;
        regWdata <= 32'h0;
        rs = 32'd93;
        brd.strap(3'h2, 1'b0, 1'b1, 3);
        for (int i = 0; i < 16; i++) begin
            rs = xs(rs);
            brd.strap(i[2:0], i[3], rs[0], 250);
            repeat (2) @(posedge sys_clk);
            #1 m = meth(i[2:0]);
            intl = (m == 2 || m == 3);
            chk(smbSlaveEn, m < 2);
            chk(smbSlaveAddr,
                m == 0 ? 7'h2C : m == 1 ? 7'h2D : 7'h00);
            chk(eepromMasterEn, m == 4);
            chk({internalCfgEn, strapOverrideEn}, {intl[0], m == 3});
            chk({extClockEn, oscDriveEn}, {i[3], !i[3]});
            chk(selfPowered, intl ? rs[0] : 1'b0);
            rd(css_pkg::REG_STATUS, d);
            chk(d, {21'h0, m[2:0], 1'b0, intl[0], 1'b0,
                    intl[0] & rs[0], i[3], i[2:0]});
            // Read data must drop back to zero after one cycle
            @(posedge sys_clk);
            #1 chk(regRdata, 32'h0);
            rd(css_pkg::REG_ADDR, d);
            chk(d, m == 0 ? 32'h2C : m == 1 ? 32'h2D : 32'h0);
            brd.pins(~i[2:0], !i[3], !rs[0]);
            repeat (6) @(posedge sys_clk);
            #1 chk({extClockEn, internalCfgEn}, {i[3], intl[0]});
            chk(selfPowered, intl ? !rs[0] : 1'b0);
            if (!intl) begin
                wr(css_pkg::REG_CTRL, {30'h0, rs[1], 1'b1});
                eOk = 1'b0;
                for (int k = 0; k < 8 && !eOk; k++) begin
                    @(posedge sys_clk);
                    #1 eOk = configReady;
                end
                chk(eOk, 1'b1);
                if (!eOk) begin
                    break;
                end
                chk({smbSlaveEn, eepromMasterEn}, 2'b00);
                chk(extClockEn, i[3]);
                chk(selfPowered, rs[1]);
                rd(css_pkg::REG_CTRL, d);
                chk(d, {30'h0, rs[1], 1'b1});
            end
            rd(8'h0C, d);
            chk(d, 32'h0);
            $display("test %0d done", i);
        end
        // Too short a reset: still captured, but flagged in status
        brd.strap(3'h6, 1'b1, 1'b1, 10);
        repeat (2) @(posedge sys_clk);
        rd(css_pkg::REG_STATUS, d);
        chk(d, 32'h37E);
        $display("short reset test done");
        tallyAndFinish();
    end
endmodule

bind css_config_select css_config_select_sva chk_i (.sys_clk, .rstn,
    .local_supply_detect, .smbSlaveEn, .smbSlaveAddr, .eepromMasterEn,
    .internalCfgEn, .strapOverrideEn, .oscDriveEn, .extClockEn,
    .selfPowered, .configReady);
